/* File: pkg/serial_buffers_pkg.sv */
// constants for the serial buffer, pin control and priority block
// assumes a 32-bit AXI4-Lite master on the register side
// How it works
// - shift-to-buffer move sets rx_char_ready
// - move raises rx request when enabled
// - reading receive buffer clears rx_char_ready
// - reset clears read-only receive buffer
// - transfer to shifter sets tx_buffer_free
// - transfer raises tx request when enabled
// - unused upper transmit bits are ignored
// - bit 7 reads serial_out_pin level
// - bit 6 drives general-purpose output pin
// - bit 5 picks gpio or transmit
// - bit 4 sets out pin direction
// - bit 3 reads serial_in_pin level
// - bit 2 drives in pin output
// - bit 1 picks gpio or receive
// - bit 0 sets in pin direction
// - tx priority bit routes high/low
// - rx priority bit routes high/low
// - freeze 0: finish current operations
// - freeze 1: stop immediately
// - reserved priority bits ignore writes
// - peek alias reads without clearing ready
package serial_buffers_pkg;
  // printed offsets are not multiples of four: kept as indices
  localparam logic [15:0] IDX_PEEK = 16'h7056;
  localparam logic [15:0] IDX_RXBUF = 16'h7057;
  localparam logic [15:0] IDX_TXBUF = 16'h7059;
  localparam logic [15:0] IDX_PINCTL = 16'h705E;
  localparam logic [15:0] IDX_PRIO = 16'h705F;
  localparam logic [15:0] IDX_CTRL = 16'h7054;
  localparam logic [15:0] IDX_STAT = 16'h705A;
  localparam int ADDR_W = 18;
  // pin control fields
  localparam int PC_OUT_IN = 7;
  localparam int PC_OUT_DO = 6;
  localparam int PC_OUT_FN = 5;
  localparam int PC_OUT_DIR = 4;
  localparam int PC_IN_IN = 3;
  localparam int PC_IN_DO = 2;
  localparam int PC_IN_FN = 1;
  localparam int PC_IN_DIR = 0;
  localparam logic [7:0] PC_WMASK = 8'h77;
  // priority fields
  localparam int PR_TX = 6;
  localparam int PR_RX = 5;
  localparam int PR_FRZ = 4;
  localparam logic [7:0] PR_WMASK = 8'h70;
  // control fields
  localparam int CT_TXIE = 0;
  localparam int CT_RXIE = 1;
  localparam logic [7:0] CT_WMASK = 8'h03;
  localparam int ST_RX_CHAR_READY = 0;
  localparam int ST_TXFREE = 1;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int CHAR_LEN_MAX = 8;
endpackage

/* File: design/serial_buffers.sv */
// serial receive/transmit buffers, pin control and interrupt priority
// assumes a framer outside that moves characters in and out of the shifters
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module serial_buffers #(
  parameter int CHAR_LEN = 8
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [serial_buffers_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [serial_buffers_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_shift_load,
  input wire logic [7:0] rx_shift_register,
  input wire logic tx_shift_take,
  output logic [7:0] tx_shift_register,
  output logic tx_char_pending,
  input wire logic emu_suspend,
  input wire logic xfer_busy,
  output logic engine_run,
  input wire logic serial_tx_bit,
  output logic serial_in_to_receiver,
  input wire logic serial_out_pin_i,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe,
  input wire logic serial_in_pin_i,
  output logic serial_in_pin_o,
  output logic serial_in_pin_oe,
  output logic rx_irq_high,
  output logic rx_irq_low,
  output logic tx_irq_high,
  output logic tx_irq_low
);
  import serial_buffers_pkg::*;

  // the mask below only serves one to eight character bits
  if (CHAR_LEN < 1 || CHAR_LEN > CHAR_LEN_MAX) begin : g_bad_char_len
    $error("CHAR_LEN out of range");
  end

  // ********************************
  // state
  // ********************************
  typedef struct packed {
    logic [7:0] rxbuf;
    logic [7:0] txbuf;
    logic [7:0] pinctl;
    logic [7:0] prio;
    logic [7:0] ctrl;
    logic rx_char_ready;
    logic tx_buffer_free;
    logic [ADDR_W-1:0] awaddr;
    logic aw_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic w_have;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rx_irq;
    logic tx_irq;
  } state_t;

  state_t s_q;
  state_t s_d;

  function automatic logic [15:0] word_index(input logic [ADDR_W-1:0] a);
    word_index = a[ADDR_W-1:2];
  endfunction

  function automatic logic known(input logic [15:0] i);
    known = (i == IDX_PEEK) || (i == IDX_RXBUF) || (i == IDX_TXBUF) ||
            (i == IDX_PINCTL) || (i == IDX_PRIO) || (i == IDX_CTRL) ||
            (i == IDX_STAT);
  endfunction

  // unused upper character bits masked on the way to the shifter
  localparam logic [7:0] CHAR_MASK = 8'(9'h1FF >> (9 - CHAR_LEN));

  logic frozen;
  logic [7:0] pinctl_view;

  // ********************************
  // pins
  // ********************************
  always_comb begin
    pinctl_view = s_q.pinctl;
    pinctl_view[PC_OUT_IN] = serial_out_pin_i;
    pinctl_view[PC_IN_IN] = serial_in_pin_i;
  end

  assign serial_out_pin_o = s_q.pinctl[PC_OUT_FN] ? serial_tx_bit
                          : s_q.pinctl[PC_OUT_DO];
  assign serial_out_pin_oe = s_q.pinctl[PC_OUT_FN] | s_q.pinctl[PC_OUT_DIR];
  assign serial_in_pin_o = s_q.pinctl[PC_IN_DO];
  assign serial_in_pin_oe = ~s_q.pinctl[PC_IN_FN] & s_q.pinctl[PC_IN_DIR];
  // idle-high line to the receiver while the pin is general-purpose
  assign serial_in_to_receiver = s_q.pinctl[PC_IN_FN] ? serial_in_pin_i : 1'b1;

  // freeze bit stops at once; otherwise wait for busy to drop
  assign frozen = emu_suspend & (s_q.prio[PR_FRZ] | ~xfer_busy);
  assign engine_run = clk_en & ~frozen;

  assign tx_shift_register = s_q.txbuf & CHAR_MASK;
  assign tx_char_pending = ~s_q.tx_buffer_free;

  assign rx_irq_high = s_q.rx_irq & ~s_q.prio[PR_RX];
  assign rx_irq_low = s_q.rx_irq & s_q.prio[PR_RX];
  assign tx_irq_high = s_q.tx_irq & ~s_q.prio[PR_TX];
  assign tx_irq_low = s_q.tx_irq & s_q.prio[PR_TX];

  assign s_axi_awready = ~s_q.aw_have & ~s_q.bvalid;
  assign s_axi_wready = ~s_q.w_have & ~s_q.bvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = ~s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;

  // ********************************
  // next state
  // ********************************
  always_comb begin
    logic [15:0] widx;
    logic [15:0] ridx;
    logic [7:0] wb;
    logic rx_move;
    logic tx_move;
    logic rd_clear;
    logic wr_tx;
    widx = 16'h0000;
    ridx = 16'h0000;
    wb = 8'h00;
    rx_move = 1'b0;
    tx_move = 1'b0;
    rd_clear = 1'b0;
    wr_tx = 1'b0;
    s_d = s_q;
    s_d.rx_irq = 1'b0;
    s_d.tx_irq = 1'b0;
    if (!frozen) begin
      rx_move = rx_shift_load;
      tx_move = tx_shift_take & ~s_q.tx_buffer_free;
    end
    // ---- write channel
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.awaddr = s_axi_awaddr;
      s_d.aw_have = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
      s_d.w_have = 1'b1;
    end
    if (s_q.aw_have && s_q.w_have) begin
      widx = word_index(s_q.awaddr);
      wb = s_q.wdata[7:0];
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = known(widx) ? RESP_OKAY : RESP_SLVERR;
      if (s_q.wstrb[0]) begin
        case (widx)
          IDX_TXBUF: begin
            s_d.txbuf = wb;
            wr_tx = 1'b1;
          end
          IDX_PINCTL: s_d.pinctl = wb & PC_WMASK;
          IDX_PRIO: s_d.prio = wb & PR_WMASK;
          IDX_CTRL: s_d.ctrl = wb & CT_WMASK;
          default: s_d.bresp = s_d.bresp;
        endcase
      end
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    // ---- read channel
    if (s_axi_arvalid && s_axi_arready) begin
      ridx = word_index(s_axi_araddr);
      s_d.rvalid = 1'b1;
      s_d.rresp = known(ridx) ? RESP_OKAY : RESP_SLVERR;
      s_d.rdata = 32'h0000_0000;
      case (ridx)
        IDX_RXBUF: begin
          s_d.rdata[7:0] = s_q.rxbuf;
          rd_clear = 1'b1;
        end
        IDX_PEEK: s_d.rdata[7:0] = s_q.rxbuf;
        IDX_TXBUF: s_d.rdata[7:0] = s_q.txbuf;
        IDX_PINCTL: s_d.rdata[7:0] = pinctl_view;
        IDX_PRIO: s_d.rdata[7:0] = s_q.prio;
        IDX_CTRL: s_d.rdata[7:0] = s_q.ctrl;
        IDX_STAT: begin
          s_d.rdata[ST_RX_CHAR_READY] = s_q.rx_char_ready;
          s_d.rdata[ST_TXFREE] = s_q.tx_buffer_free;
        end
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    // ---- buffers; set wins over clear
    if (rd_clear) begin
      s_d.rx_char_ready = 1'b0;
    end
    if (rx_move) begin
      s_d.rxbuf = rx_shift_register;
      s_d.rx_char_ready = 1'b1;
      s_d.rx_irq = s_q.ctrl[CT_RXIE];
    end
    if (wr_tx) begin
      s_d.tx_buffer_free = 1'b0;
    end
    if (tx_move) begin
      s_d.tx_buffer_free = 1'b1;
      s_d.tx_irq = s_q.ctrl[CT_TXIE];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_q <= '0;
      s_q.rxbuf <= RESET_BYTE;
      s_q.txbuf <= RESET_BYTE;
      s_q.tx_buffer_free <= 1'b1;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

/* File: tb/serial_buffers_properties.sv */
// port assertions for serial_buffers
// bound to the block; clk_en held high
`timescale 1ns/1ps
`default_nettype none
module serial_buffers_properties #(parameter int CHAR_LEN = 8) (
  input wire logic clk_sys, reset, emu_suspend, xfer_busy, engine_run,
  input wire logic rx_shift_load, tx_shift_take, tx_char_pending,
  input wire logic [7:0] tx_shift_register,
  input wire logic serial_in_pin_i, serial_in_pin_oe, serial_in_to_receiver,
  input wire logic rx_irq_high, rx_irq_low, tx_irq_high, tx_irq_low
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  //****
  // checks
  //****
  a_rx_irq_cause: assert property ((rx_irq_high || rx_irq_low) |-> $past(rx_shift_load))
    else $error("rx irq cause");
  a_tx_irq_cause: assert property ((tx_irq_high || tx_irq_low) |-> $past(tx_shift_take))
    else $error("tx irq cause");
  a_tx_take_clr: assert property (tx_shift_take && tx_char_pending && engine_run
    |=> !tx_char_pending) else $error("tx take");
  a_tx_upper_zero: assert property ((tx_shift_register >> CHAR_LEN) == 8'h00)
    else $error("tx upper bits");
  a_rx_one_level: assert property (!(rx_irq_high && rx_irq_low))
    else $error("rx route");
  a_tx_one_level: assert property (!(tx_irq_high && tx_irq_low))
    else $error("tx route");
  a_recv_follows_pin: assert property (!serial_in_to_receiver |-> !serial_in_pin_i)
    else $error("receiver pin");
  a_recv_gpio_idle: assert property (serial_in_pin_oe |-> serial_in_to_receiver)
    else $error("receiver gpio");
  a_suspend_idle: assert property (emu_suspend && !xfer_busy |-> !engine_run)
    else $error("suspend halt");
  c_rx_low: cover property (rx_irq_low);
  c_tx_low: cover property (tx_irq_low);
  c_halt: cover property (emu_suspend && !engine_run);
endmodule
bind serial_buffers serial_buffers_properties #(.CHAR_LEN(CHAR_LEN)) u_chk (.*);
`default_nettype wire

/* File: tb/remote_serial_model.sv */
// far-end serial device on both pins
// drives a pin only while the block leaves it released
`timescale 1ns/1ps
`default_nettype none
module remote_serial_model (
  input wire logic out_o, out_oe, in_o, in_oe, out_drv, in_drv,
  output logic out_level, in_level
);
  assign out_level = out_oe ? out_o : out_drv;
  assign in_level = in_oe ? in_o : in_drv;
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for serial_buffers
// remote model closes both pin loops
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import serial_buffers_pkg::*;
  logic clk_sys, reset, clk_en, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, rx_shift_load, tx_shift_take, emu_suspend, xfer_busy, serial_tx_bit;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic engine_run, serial_in_to_receiver, serial_out_pin_o, serial_out_pin_oe, serial_in_pin_o;
  logic serial_in_pin_oe, rx_irq_high, rx_irq_low, tx_irq_high, tx_irq_low, tx_char_pending;
  logic serial_out_pin_i, serial_in_pin_i, out_drv, in_drv;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] rx_shift_register, tx_shift_register;
  int err_total = 0;
  int num_checks = 0;
  serial_buffers #(.CHAR_LEN(7)) u_dut (.*);
  remote_serial_model u_far (.out_o(serial_out_pin_o), .out_oe(serial_out_pin_oe),
    .in_o(serial_in_pin_o), .in_oe(serial_in_pin_oe), .out_drv(out_drv), .in_drv(in_drv),
    .out_level(serial_out_pin_i), .in_level(serial_in_pin_i));
  //****
  // bus tasks
  //****
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // handshakes sampled at negedge, so no race with the design's own edge
  task automatic wr(logic [15:0] i, logic [7:0] d);
    logic a, w, b;
    logic [1:0] p;
    @(posedge clk_sys);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clk_sys);
      a = s_axi_awready;
      w = s_axi_wready;
      b = s_axi_bvalid;
      p = s_axi_bresp;
      @(posedge clk_sys);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (!b);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(p), 32'(RESP_OKAY));
  endtask
  task automatic rdc(string n, logic [15:0] i, logic [31:0] e, logic [1:0] r = RESP_OKAY);
    logic a, v;
    logic [31:0] d;
    logic [1:0] p;
    @(posedge clk_sys);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clk_sys);
      a = s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      p = s_axi_rresp;
      @(posedge clk_sys);
      if (a) s_axi_arvalid <= 1'b0;
    end while (!v);
    s_axi_rready <= 1'b0;
    chk(n, d, e);
    chk("resp", 32'(p), 32'(r));
  endtask
  task automatic pulse(logic rx);
    @(posedge clk_sys);
    if (rx) rx_shift_load <= 1'b1;
    else tx_shift_take <= 1'b1;
    @(posedge clk_sys);
    rx_shift_load <= 1'b0;
    tx_shift_take <= 1'b0;
    @(negedge clk_sys);
  endtask
  //****
  // scenarios
  //****
  task automatic t_rx;
    wr(IDX_CTRL, 8'h02);
    wr(IDX_PRIO, 8'h20);
    rx_shift_register <= 8'hA5;
    pulse(1'b1);
    chk("rx irq", 32'({rx_irq_high, rx_irq_low}), 32'h1);
    rdc("stat", IDX_STAT, 32'h3);
    rdc("peek", IDX_PEEK, 32'hA5);
    rdc("stat", IDX_STAT, 32'h3);
    rdc("rxbuf", IDX_RXBUF, 32'hA5);
    rdc("stat", IDX_STAT, 32'h2);
    wr(IDX_PRIO, 8'h00);
    pulse(1'b1);
    chk("rx irq", 32'({rx_irq_high, rx_irq_low}), 32'h2);
    wr(IDX_CTRL, 8'h00);
    pulse(1'b1);
    chk("rx irq", 32'({rx_irq_high, rx_irq_low}), 32'h0);
    $display("rx test done");
  endtask
  task automatic t_tx;
    wr(IDX_CTRL, 8'h01);
    wr(IDX_PRIO, 8'h40);
    wr(IDX_TXBUF, 8'hFF);
    chk("shifter", 32'(tx_shift_register), 32'h7F);
    chk("pending", 32'(tx_char_pending), 32'h1);
    rdc("stat", IDX_STAT, 32'h1);
    pulse(1'b0);
    chk("tx irq", 32'({tx_irq_high, tx_irq_low}), 32'h1);
    chk("pending", 32'(tx_char_pending), 32'h0);
    rdc("stat", IDX_STAT, 32'h3);
    $display("tx test done");
  endtask
  task automatic t_pins;
    wr(IDX_PINCTL, 8'h50);
    rdc("pins", IDX_PINCTL, 32'hD0);
    wr(IDX_PINCTL, 8'h66);
    chk("out pin", 32'({serial_out_pin_oe, serial_out_pin_o}), 32'h2);
    chk("in pin", 32'({serial_in_pin_oe, serial_in_to_receiver}), 32'h0);
    wr(IDX_PINCTL, 8'h05);
    chk("in gpio", 32'({serial_in_pin_oe, serial_in_pin_o}), 32'h3);
    chk("out oe", 32'(serial_out_pin_oe), 32'h0);
    $display("pin test done");
  endtask
  task automatic t_susp;
    wr(IDX_PRIO, 8'hFF);
    rdc("prio", IDX_PRIO, 32'h70);
    rdc("unmapped", 16'h7000, 32'h0, RESP_SLVERR);
    emu_suspend <= 1'b1;
    xfer_busy <= 1'b1;
    @(negedge clk_sys);
    chk("run", 32'(engine_run), 32'h0);
    @(posedge clk_sys);
    emu_suspend <= 1'b0;
    wr(IDX_PRIO, 8'h00);
    emu_suspend <= 1'b1;
    @(negedge clk_sys);
    chk("run", 32'(engine_run), 32'h1);
    @(posedge clk_sys);
    xfer_busy <= 1'b0;
    @(negedge clk_sys);
    chk("run", 32'(engine_run), 32'h0);
    $display("suspend test done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #100000;
    err_total++;
    finish_test();
  end
  initial begin
    {reset, clk_en, s_axi_wstrb, out_drv} = 7'h7F;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {rx_shift_load, tx_shift_take, emu_suspend, xfer_busy, serial_tx_bit, in_drv} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rx_shift_register} = '0;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    rdc("rxbuf", IDX_RXBUF, 32'h0);
    rdc("stat", IDX_STAT, 32'h2);
    rdc("pins", IDX_PINCTL, 32'h80);
    t_rx();
    t_tx();
    t_pins();
    t_susp();
    finish_test();
  end
endmodule
`default_nettype wire
